/* src/scr_map.svh */
// Bit positions, field limits and reset values of the slow channel receiver
`ifndef SCR_MAP_SVH
`define SCR_MAP_SVH

// ****************************************
// Channel layout
// ****************************************
`define SCR_PARCEL_W 16
`define SCR_PARITY_W 4
`define SCR_NIBBLE_W 4
`define SCR_ROUTE_BIT 15
`define SCR_WORD_PARCELS 4
`define SCR_BUF_PARCELS 128

// ****************************************
// Event flags, clear bits and error bits
// ****************************************
`define SCR_FLAG_DAV 7
`define SCR_FLAG_DISC 8
`define SCR_FLAG_ERR 9
`define SCR_CLR_ERRS 7
`define SCR_CLR_DISC 9
`define SCR_CLR_DAV 10
`define SCR_ERR_PAR 3
`define SCR_ERR_SEQ 4
`define SCR_ERR_CNT_LO 5
`define SCR_ERR_CNT_HI 7
`define SCR_REG_W 16
`define SCR_REG_RST 16'h0000
`define SCR_CNT_FULL 3'h4
`define SCR_CNT_ZERO 3'h0

`endif

/* src/scr_pkg.sv */
// Types shared by the slow channel receiver files
package scr_pkg;

    // ****************************************
    // Channel bundle and buffered parcel
    // ****************************************
    typedef struct packed {
        logic [15:0] data;
        logic [3:0] parity;
        logic ready;
        logic disconnect;
    } scr_chan_type;

    typedef struct packed {
        logic [15:0] data;
        logic perr;
    } scr_parcel_type;

    // ****************************************
    // State encodings
    // ****************************************
    typedef enum logic [1:0] {
        XF_IDLE = 2'b00,
        XF_ACTIVE = 2'b01,
        XF_DRAIN = 2'b10,
        XF_DONE = 2'b11
    } scr_xfer_state_type;

    typedef enum logic {
        RD_IDLE = 1'b0,
        RD_WAIT = 1'b1
    } scr_rd_state_type;

endpackage : scr_pkg

/* src/scr_fifo.sv */
// Parcel buffer between the channel capture and the data-in word loader
module scr_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 128
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Fill side
    input wire logic [WIDTH-1:0] i_in_data,
    input wire logic i_in_valid,
    output logic o_in_ready,
    // Drain side
    output logic [WIDTH-1:0] o_out_data,
    output logic o_out_valid,
    input wire logic i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [AW:0] count_reg, count_next;
    logic push, pop;

    assign o_in_ready = (count_reg != (AW+1)'(DEPTH));
    assign o_out_valid = (count_reg != '0);
    assign o_out_data = mem_reg[rd_ptr_reg];

    always_comb begin
        push = i_in_valid && o_in_ready;
        pop = o_out_valid && i_out_ready;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next = count_reg;
        if (push) begin
            wr_ptr_next = (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
        end
        if (pop) begin
            rd_ptr_next = (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
        end
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
        end
    end

    // Storage carries no reset; emptiness is held by the occupancy count alone
    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= i_in_data;
        end
    end

endmodule : scr_fifo

/* src/scr_receiver.sv */
// Receive side of the low speed channel: capture, routing, packing and flags
`include "scr_map.svh"

module scr_receiver #(
    parameter int BUF_PARCELS = `SCR_BUF_PARCELS
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Channel from the sender
    input scr_pkg::scr_chan_type i_chan,
    output logic o_resume,
    // Data-in word read port
    input wire logic i_word_rd,
    output logic [63:0] o_word_data,
    output logic o_word_ack,
    // Flags, mask, clear and errors
    input wire logic [15:0] i_event_mask,
    input wire logic i_clr_wr,
    input wire logic [15:0] i_clr_data,
    output logic [15:0] o_event_flags,
    output logic [15:0] o_err_flags,
    output logic o_node_sel,
    // Interrupts to the two node processors
    output logic o_irq_input_node,
    output logic o_irq_output_node
);
    import scr_pkg::*;

    // ****************************************
    // State
    // ****************************************
    scr_xfer_state_type xfer_state_reg, xfer_state_next;
    scr_rd_state_type rd_state_reg, rd_state_next;
    scr_parcel_type hold_reg, hold_next, fifo_out;
    logic hold_valid_reg, hold_valid_next;
    logic node_reg, node_next;
    logic rdy_prev_reg, disc_prev_reg;
    logic full_stall_reg, full_stall_next;
    logic [63:0] word_reg, word_next;
    logic [2:0] word_cnt_reg, word_cnt_next;
    logic [63:0] out_word_reg, out_word_next;
    logic ack_reg, ack_next;
    logic resume_reg, resume_next;
    logic [15:0] flags_reg, flags_next;
    logic [15:0] err_reg, err_next;
    logic irq_in_reg, irq_in_next, irq_out_reg, irq_out_next;
    logic rdy_edge, disc_edge, fifo_in_valid, fifo_in_ready, fifo_out_valid;
    logic pop_en, rd_pend, read_ok, last_word, irq_any;
    logic [15:0] irq_sel;

    assign o_resume = resume_reg;
    assign o_word_data = out_word_reg;
    assign o_word_ack = ack_reg;
    assign o_event_flags = flags_reg;
    assign o_err_flags = err_reg;
    assign o_node_sel = node_reg;
    assign o_irq_input_node = irq_in_reg;
    assign o_irq_output_node = irq_out_reg;

    // Even parity over each nibble; one parity lane per nibble
    function automatic logic parity_bad(input logic [15:0] d, input logic [3:0] p);
        logic bad;
        bad = 1'b0;
        for (int i = 0; i < `SCR_PARITY_W; i++) begin
            bad = bad | (p[i] ^ (^d[i*`SCR_NIBBLE_W +: `SCR_NIBBLE_W]));
        end
        return bad;
    endfunction : parity_bad

    // ****************************************
    // Parcel buffer
    // ****************************************
    scr_fifo #(
        .WIDTH($bits(scr_parcel_type)),
        .DEPTH(BUF_PARCELS)
    ) u_buf (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_in_data(hold_reg),
        .i_in_valid(fifo_in_valid),
        .o_in_ready(fifo_in_ready),
        .o_out_data(fifo_out),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(pop_en)
    );

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        rdy_edge = i_chan.ready && !rdy_prev_reg;
        disc_edge = i_chan.disconnect && !disc_prev_reg;
        xfer_state_next = xfer_state_reg;
        rd_state_next = rd_state_reg;
        hold_next = hold_reg;
        hold_valid_next = hold_valid_reg;
        node_next = node_reg;
        full_stall_next = full_stall_reg;
        word_next = word_reg;
        word_cnt_next = word_cnt_reg;
        out_word_next = out_word_reg;
        ack_next = 1'b0;
        resume_next = 1'b0;
        flags_next = flags_reg;
        err_next = err_reg;

        // Clears are applied first so that a same-cycle set below wins
        if (i_clr_wr && i_clr_data[`SCR_CLR_DAV]) begin
            flags_next[`SCR_FLAG_DAV] = 1'b0;
        end
        if (i_clr_wr && i_clr_data[`SCR_CLR_DISC]) begin
            flags_next[`SCR_FLAG_DISC] = 1'b0;
        end
        if (i_clr_wr && i_clr_data[`SCR_CLR_ERRS]) begin
            err_next[`SCR_ERR_SEQ] = 1'b0;
            err_next[`SCR_ERR_PAR] = 1'b0;
            flags_next[`SCR_FLAG_DISC] = 1'b0;
            flags_next[`SCR_FLAG_ERR] = 1'b0;
        end
        if (xfer_state_reg == XF_DONE && i_clr_wr
                && (i_clr_data[`SCR_CLR_DISC] || i_clr_data[`SCR_CLR_ERRS])) begin
            xfer_state_next = XF_IDLE;
            full_stall_next = 1'b0;
        end

        // Capture a parcel on the leading edge of Ready
        if (rdy_edge) begin
            if (hold_valid_reg) begin
                // Previous parcel not yet answered; keep it, flag a sequence error
                err_next[`SCR_ERR_SEQ] = 1'b1;
                flags_next[`SCR_FLAG_ERR] = 1'b1;
            end else begin
                case (xfer_state_reg)
                    XF_IDLE: begin
                        node_next = i_chan.data[`SCR_ROUTE_BIT];
                        xfer_state_next = XF_ACTIVE;
                        hold_next = '{data: i_chan.data,
                                      perr: parity_bad(i_chan.data, i_chan.parity)};
                        hold_valid_next = 1'b1;
                    end
                    XF_ACTIVE: begin
                        // Routing stays as latched from the first parcel
                        hold_next = '{data: i_chan.data,
                                      perr: parity_bad(i_chan.data, i_chan.parity)};
                        hold_valid_next = 1'b1;
                    end
                    default: begin
                        hold_valid_next = hold_valid_reg;
                    end
                endcase
            end
        end

        // Disconnect ends acceptance and tells software data is waiting
        if (disc_edge && (xfer_state_reg == XF_IDLE || xfer_state_reg == XF_ACTIVE)) begin
            xfer_state_next = XF_DRAIN;
            flags_next[`SCR_FLAG_DAV] = 1'b1;
        end

        // Push held parcel; Resume answers only once it is stored
        fifo_in_valid = hold_valid_reg && !(full_stall_reg && flags_reg[`SCR_FLAG_DAV]);
        if (fifo_in_valid && fifo_in_ready) begin
            hold_valid_next = 1'b0;
            resume_next = 1'b1;
            full_stall_next = 1'b0;
        end else if (xfer_state_reg == XF_ACTIVE && !fifo_in_ready && !full_stall_reg) begin
            // Word and buffer hold 132 parcels: report now, withhold the next Resume
            full_stall_next = 1'b1;
            flags_next[`SCR_FLAG_DAV] = 1'b1;
        end

        // Read answers once four parcels or the tail of a transfer are ready
        rd_pend = i_word_rd || (rd_state_reg == RD_WAIT);
        last_word = (xfer_state_reg == XF_DRAIN || xfer_state_reg == XF_DONE)
                    && !fifo_out_valid && !hold_valid_reg;
        read_ok = (word_cnt_reg == `SCR_CNT_FULL) || last_word;
        if (rd_pend && read_ok) begin
            out_word_next = word_reg;
            ack_next = 1'b1;
            err_next[`SCR_ERR_CNT_HI:`SCR_ERR_CNT_LO] = word_cnt_reg;
            word_next = '0;
            word_cnt_next = `SCR_CNT_ZERO;
            rd_state_next = RD_IDLE;
            if (last_word) begin
                flags_next[`SCR_FLAG_DISC] = 1'b1;
                xfer_state_next = XF_DONE;
            end
        end else if (rd_pend) begin
            rd_state_next = RD_WAIT;
        end

        // Loader fills the data-in word from the buffer, one parcel a cycle
        pop_en = fifo_out_valid && (word_cnt_reg != `SCR_CNT_FULL) && !(rd_pend && read_ok);
        if (pop_en) begin
            word_next[word_cnt_reg[1:0]*`SCR_PARCEL_W +: `SCR_PARCEL_W] = fifo_out.data;
            word_cnt_next = word_cnt_reg + 3'h1;
            if (fifo_out.perr) begin
                err_next[`SCR_ERR_PAR] = 1'b1;
                flags_next[`SCR_FLAG_ERR] = 1'b1;
            end
        end

        // Flags are kept unmasked; the mask gates only the interrupt
        irq_sel = flags_next & i_event_mask;
        irq_any = irq_sel[`SCR_FLAG_DAV] || irq_sel[`SCR_FLAG_DISC]
                  || irq_sel[`SCR_FLAG_ERR];
        irq_in_next = irq_any && node_next;
        irq_out_next = irq_any && !node_next;
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            xfer_state_reg <= XF_IDLE;
            rd_state_reg <= RD_IDLE;
            hold_reg <= '0;
            hold_valid_reg <= 1'b0;
            node_reg <= 1'b0;
            rdy_prev_reg <= 1'b0;
            disc_prev_reg <= 1'b0;
            full_stall_reg <= 1'b0;
            word_reg <= '0;
            word_cnt_reg <= `SCR_CNT_ZERO;
            out_word_reg <= '0;
            ack_reg <= 1'b0;
            resume_reg <= 1'b0;
            flags_reg <= `SCR_REG_RST;
            err_reg <= `SCR_REG_RST;
            irq_in_reg <= 1'b0;
            irq_out_reg <= 1'b0;
        end else begin
            xfer_state_reg <= xfer_state_next;
            rd_state_reg <= rd_state_next;
            hold_reg <= hold_next;
            hold_valid_reg <= hold_valid_next;
            node_reg <= node_next;
            rdy_prev_reg <= i_chan.ready;
            disc_prev_reg <= i_chan.disconnect;
            full_stall_reg <= full_stall_next;
            word_reg <= word_next;
            word_cnt_reg <= word_cnt_next;
            out_word_reg <= out_word_next;
            ack_reg <= ack_next;
            resume_reg <= resume_next;
            flags_reg <= flags_next;
            err_reg <= err_next;
            irq_in_reg <= irq_in_next;
            irq_out_reg <= irq_out_next;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    route_first_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (xfer_state_reg == XF_IDLE && rdy_edge && !hold_valid_reg)
        |=> node_reg == $past(i_chan.data[`SCR_ROUTE_BIT]))
        else $error("node select does not follow the first parcel routing bit");

    route_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (xfer_state_reg == XF_ACTIVE) |=> $stable(node_reg))
        else $error("node select changed inside a transfer");

    dav_on_disc_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (disc_edge && xfer_state_reg == XF_ACTIVE)
        |=> flags_reg[`SCR_FLAG_DAV] && xfer_state_reg == XF_DRAIN)
        else $error("disconnect did not raise data-available");

    irq_route_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_irq_input_node |-> node_reg && !o_irq_output_node)
        else $error("interrupt went to the wrong node");

    dav_clear_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_clr_wr && i_clr_data[`SCR_CLR_DAV] && !disc_edge
            && (fifo_in_ready || full_stall_reg))
        |=> !flags_reg[`SCR_FLAG_DAV])
        else $error("data-available survived its clear");

    count_range_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_word_ack |-> err_reg[`SCR_ERR_CNT_HI:`SCR_ERR_CNT_LO] <= `SCR_CNT_FULL)
        else $error("valid parcel count above four");

    seq_err_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (rdy_edge && hold_valid_reg)
        |=> err_reg[`SCR_ERR_SEQ] && flags_reg[`SCR_FLAG_ERR])
        else $error("early Ready did not flag a sequence error");

    full_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (full_stall_reg && flags_reg[`SCR_FLAG_DAV]) |=> !o_resume)
        else $error("Resume issued while the full buffer awaits software");

    read_stall_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_word_rd && xfer_state_reg == XF_ACTIVE && word_cnt_reg != `SCR_CNT_FULL)
        |=> !o_word_ack)
        else $error("read answered without data or disconnect");

    full_dav_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (xfer_state_reg == XF_ACTIVE && !fifo_in_ready && !full_stall_reg)
        |=> flags_reg[`SCR_FLAG_DAV] && full_stall_reg)
        else $error("full buffer did not raise data-available");

    resume_release_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (full_stall_reg && hold_valid_reg && fifo_in_ready && !flags_reg[`SCR_FLAG_DAV])
        |=> o_resume)
        else $error("withheld Resume not issued after clear");

    clear_idle_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (xfer_state_reg == XF_DONE && i_clr_wr && i_clr_data[`SCR_CLR_DISC] && !rd_pend)
        |=> xfer_state_reg == XF_IDLE && !flags_reg[`SCR_FLAG_DISC])
        else $error("disconnect clear did not free the node");

endmodule : scr_receiver

/* verif/scr_host_model.sv */
// Behavioural model of the host sender on the low speed channel
module scr_host_model (
    // Clock
    input wire logic i_clk_sys,
    // Channel towards the receiver
    input wire logic i_resume,
    output scr_pkg::scr_chan_type o_chan
);
    timeunit 1ns;
    timeprecision 1ps;
    import scr_pkg::*;

    int n_res = 0;

    initial begin
        o_chan = '0;
    end

    always @(posedge i_clk_sys) begin
        if (i_resume) begin
            n_res <= n_res + 1;
        end
    end

    // ****************************************
    // Parcel handshake
    // ****************************************
    function automatic logic [3:0] par(input logic [15:0] d);
        logic [3:0] p;
        for (int i = 0; i < 4; i++) begin
            p[i] = ^d[4*i+:4];
        end
        return p;
    endfunction : par

    // Bad parity flips one check bit so the parcel is caught when loaded
    task automatic raise(input logic [15:0] d, input logic bad);
        @(negedge i_clk_sys);
        o_chan.data = d;
        o_chan.parity = par(d) ^ {3'h0, bad};
        o_chan.ready = 1'b1;
    endtask : raise

    // Released lines show the inverse so stale data never looks valid
    task automatic drop();
        @(negedge i_clk_sys);
        o_chan.ready = 1'b0;
        o_chan.data = ~o_chan.data;
        o_chan.parity = ~o_chan.parity;
    endtask : drop

    task automatic wait_res(input int base);
        int k;
        k = 0;
        while (n_res == base && k < 200) begin
            @(posedge i_clk_sys);
            k++;
        end
    endtask : wait_res

    task automatic send(input logic [15:0] d, input logic bad);
        int b;
        b = n_res;
        raise(d, bad);
        wait_res(b);
        drop();
    endtask : send

    task automatic disc();
        @(negedge i_clk_sys);
        o_chan.disconnect = 1'b1;
        repeat (2) @(negedge i_clk_sys);
        o_chan.disconnect = 1'b0;
    endtask : disc

endmodule : scr_host_model

/* verif/scr_receiver_tb.sv */
// Self-checking bench of the slow channel receiver
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end

module scr_receiver_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import scr_pkg::*;

    // Small buffer keeps the full case short: 4 in word plus 8 buffered
    localparam int BUF = 8;
    logic clk, rst, word_rd, word_ack, clr_wr, resume, node_sel, irq_in, irq_out;
    logic [15:0] mask, clr_data, flags, errs;
    logic [63:0] word_data;
    scr_chan_type chan;
    int n_errors = 0;
    int check_count = 0;
    int n_ack = 0;
    int b;
    logic [15:0] exp_q[$];

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        if (word_ack) begin
            n_ack <= n_ack + 1;
        end
    end

    scr_receiver #(.BUF_PARCELS(BUF)) u_dut (
        .i_clk_sys(clk), .i_rst(rst), .i_chan(chan), .o_resume(resume),
        .i_word_rd(word_rd), .o_word_data(word_data), .o_word_ack(word_ack),
        .i_event_mask(mask), .i_clr_wr(clr_wr), .i_clr_data(clr_data),
        .o_event_flags(flags), .o_err_flags(errs), .o_node_sel(node_sel),
        .o_irq_input_node(irq_in), .o_irq_output_node(irq_out)
    );

    scr_host_model u_host (.i_clk_sys(clk), .i_resume(resume), .o_chan(chan));

    // ****************************************
    // Access tasks
    // ****************************************
    task automatic send(input logic [15:0] d, input logic bad);
        int b0;
        b0 = u_host.n_res;
        exp_q.push_back(d);
        u_host.send(d, bad);
        `CHK("parcel resume", 1'b1, u_host.n_res != b0)
    endtask : send

    task automatic rd_word();
        @(negedge clk);
        word_rd = 1'b1;
        @(negedge clk);
        word_rd = 1'b0;
    endtask : rd_word

    // Waits on the ack counter, so an ack during another task is not lost
    task automatic get_word(input int base, input int n, input logic last);
        int k;
        logic [15:0] e;
        k = 0;
        while (n_ack == base && k < 100) begin
            @(posedge clk);
            k++;
        end
        @(negedge clk);
        `CHK("word ack", 1'b1, n_ack != base)
        for (int i = 0; i < n; i++) begin
            e = exp_q.pop_front();
            `CHK("word parcel", e, word_data[16*i+:16])
        end
        `CHK("parcel count", 3'(n), errs[7:5])
        `CHK("disconnect flag", last, flags[8])
    endtask : get_word

    task automatic read_chk(input int n, input logic last);
        int bb;
        bb = n_ack;
        rd_word();
        get_word(bb, n, last);
    endtask : read_chk

    task automatic clr(input logic [15:0] v);
        @(negedge clk);
        clr_wr = 1'b1;
        clr_data = v;
        @(negedge clk);
        clr_wr = 1'b0;
        repeat (2) @(negedge clk);
    endtask : clr

    task automatic summarize();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        summarize();
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        rst = 1'b1;
        word_rd = 1'b0;
        clr_wr = 1'b0;
        clr_data = 16'h0000;
        mask = 16'h0000;
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        `CHK("flags after reset", 16'h0000, flags)
        `CHK("errors after reset", 16'h0000, errs)
        `CHK("resume after reset", 1'b0, resume)
        // Input node transfer, later parcels carry a zero routing bit
        mask = 16'h0180;
        send(16'h8001, 1'b0);
        for (int i = 1; i < 6; i++) begin
            send(16'h1230 + 16'(i), 1'b0);
        end
        u_host.disc();
        repeat (3) @(negedge clk);
        `CHK("data available", 1'b1, flags[7])
        `CHK("node select", 1'b1, node_sel)
        `CHK("irq input node", 1'b1, irq_in)
        `CHK("irq output node", 1'b0, irq_out)
        read_chk(4, 1'b0);
        read_chk(2, 1'b1);
        clr(16'h0400);
        `CHK("data available cleared", 1'b0, flags[7])
        `CHK("irq after last word", 1'b1, irq_in)
        clr(16'h0200);
        `CHK("disconnect cleared", 1'b0, flags[8])
        // Output node transfer, masked, with a bad parity parcel
        mask = 16'h0000;
        send(16'h0005, 1'b0);
        send(16'h0006, 1'b1);
        send(16'h0007, 1'b0);
        send(16'h0008, 1'b0);
        u_host.disc();
        repeat (3) @(negedge clk);
        `CHK("flag with mask off", 1'b1, flags[7])
        `CHK("node select", 1'b0, node_sel)
        `CHK("irq masked", 1'b0, irq_out)
        read_chk(4, 1'b1);
        `CHK("parity error", 1'b1, errs[3])
        `CHK("input error flag", 1'b1, flags[9])
        mask = 16'h0200;
        repeat (3) @(negedge clk);
        `CHK("irq on error", 1'b1, irq_out)
        `CHK("irq other node", 1'b0, irq_in)
        clr(16'h0480);
        `CHK("flags after clear", 16'h0000, flags)
        `CHK("parity error cleared", 1'b0, errs[3])
        // Read that must wait for the disconnect
        mask = 16'h0000;
        send(16'h8100, 1'b0);
        send(16'h8101, 1'b0);
        b = n_ack;
        rd_word();
        repeat (20) @(negedge clk);
        `CHK("stalled read", 1'b1, n_ack == b)
        u_host.disc();
        get_word(b, 2, 1'b1);
        clr(16'h0600);
        // Full buffer: withheld resume, sequence error, release by clear
        mask = 16'h0080;
        for (int i = 0; i < 12; i++) begin
            send((i == 0) ? 16'h8200 : 16'h0200 + 16'(i), 1'b0);
        end
        repeat (3) @(negedge clk);
        `CHK("full data available", 1'b1, flags[7])
        `CHK("full irq", 1'b1, irq_in)
        b = u_host.n_res;
        exp_q.push_back(16'h020c);
        u_host.raise(16'h020c, 1'b0);
        repeat (20) @(negedge clk);
        `CHK("resume withheld", 1'b1, u_host.n_res == b)
        u_host.drop();
        u_host.raise(16'h020c, 1'b0);
        repeat (3) @(negedge clk);
        `CHK("sequence error", 1'b1, errs[4])
        `CHK("input error flag", 1'b1, flags[9])
        read_chk(4, 1'b0);
        clr(16'h0400);
        u_host.wait_res(b);
        `CHK("resume released", 1'b1, u_host.n_res == b + 1)
        u_host.drop();
        u_host.disc();
        read_chk(4, 1'b0);
        read_chk(4, 1'b0);
        read_chk(1, 1'b1);
        clr(16'h0480);
        `CHK("sequence error cleared", 1'b0, errs[4])
        summarize();
    end

endmodule : scr_receiver_tb
